// ### rtl/sfm_pkg.sv
// Package for the status word and code map block
// Summary of operation
// - Carry bit 7 from add carry or borrow
// - Half carry bit 6 from nibble carry/borrow
// - Bits 5 and 1 are software-only flags
// - Bank select bits 4:3 pick register bank
// - Overflow on signed add/add_with_carry/subtract_with_borrow overflow
// - Overflow when multiply product exceeds 255
// - Overflow on divide by zero
// - Those instructions clear overflow otherwise
// - Parity bit 0 read-only, odd accumulator ones
// - Status word at 0xD0, bit/byte, resets zero
// - Sixty-four kilobyte program address space
// - Instruction type selects program or data space
// - Largest variant has 8192 bytes code
// - Top 512 bytes reserved for factory
// - Smaller variants have 4096, 2048, 1536 bytes
// - No code writes; byte reads allowed
// - Eight registers per bank, one active
package sfm_pkg;
  localparam logic [7:0]  PSW_ADDR      = 8'hD0;
  localparam logic [7:0]  PSW_RESET     = 8'h00;
  localparam int          BIT_CY        = 7;
  localparam int          BIT_AC        = 6;
  localparam int          BIT_UF0       = 5;
  localparam int          BIT_BS_HI     = 4;
  localparam int          BIT_BS_LO     = 3;
  localparam int          BIT_OV        = 2;
  localparam int          BIT_UF1       = 1;
  localparam int          BIT_PAR       = 0;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
  localparam int          CODE_AW       = 16;
  localparam logic [16:0] CODE_SPACE    = 17'h10000;
  localparam logic [15:0] SIZE_V0       = 16'h2000;
  localparam logic [15:0] SIZE_V1       = 16'h1000;
  localparam logic [15:0] SIZE_V2       = 16'h0800;
  localparam logic [15:0] SIZE_V3       = 16'h0600;
  localparam logic [15:0] FACTORY_BASE  = 16'h1E00;
  localparam logic [15:0] FACTORY_TOP   = 16'h1FFF;
  localparam int          BANK_REGS     = 8;

  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_MUL, OP_DIV, OP_OTHER
  } sfm_op_type;

  typedef struct packed {
    sfm_op_type op;
    logic [7:0] a;
    logic [7:0] b;
  } sfm_alu_type;
endpackage : sfm_pkg

// ### rtl/sfm_status_code.sv
// Status word flags, register bank mapping and code space map
//
// Implementation choice: the strobed register port.
module sfm_status_code (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Arithmetic event from the core, one cycle
  input  wire sfm_pkg::sfm_alu_type alu_in,
  input  wire logic [7:0]          acc_value,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic                bit_mode,
  input  wire logic [2:0]          bit_sel,
  output logic [7:0]               reg_rdata,
  // Register bank addressing
  input  wire logic [2:0]          work_reg_idx,
  output logic [7:0]               work_reg_addr,
  output logic [1:0]               bank_select,
  // Code space
  input  wire logic [1:0]          variant_sel,
  input  wire logic                code_rd,
  input  wire logic                code_wr,
  input  wire logic [15:0]         code_addr,
  output logic                     code_mem_en,
  output logic [15:0]              code_mem_addr,
  output logic                     code_in_range,
  output logic                     code_factory,
  output logic                     code_wr_blocked,
  // Flag view
  output logic [7:0]               program_status_word
);
  // Stored fields are split into registers by writing process (CY and AC share one) so that every process owns its bits
  logic [1:0]  cyac_r;
  logic        uf0_r;
  logic [1:0]  bank_r;
  logic        ov_r;
  logic        uf1_r;
  logic [7:0]  rdata_r;
  logic        parity;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;
  logic        cin;
  logic        sub;
  logic [7:0]  bop;
  logic        ovf_add;
  logic        hw_wr;
  logic [15:0] code_size;
  sfm_pkg::sfm_op_type op;

  assign op  = alu_in.op;
  assign cin = cyac_r[1];
  assign sub = (op == sfm_pkg::OP_SUBTRACT_WITH_BORROW);
  assign bop = sub ? ~alu_in.b : alu_in.b;

  // Subtract as a + ~b + ~borrow; carry out inverted gives borrow
  always_comb begin
    logic c0;
    c0 = 1'b0;
    case (op)
      sfm_pkg::OP_ADD_WITH_CARRY: c0 = cin;
      sfm_pkg::OP_SUBTRACT_WITH_BORROW: c0 = ~cin;
      default:          c0 = 1'b0;
    endcase
    sum9 = {1'b0, alu_in.a} + {1'b0, bop} + {8'h00, c0};
    nib5 = {1'b0, alu_in.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, c0};
  end

  assign ovf_add = (alu_in.a[7] == bop[7]) && (sum9[7] != alu_in.a[7]);
  assign prod    = alu_in.a * alu_in.b;
  assign parity  = ^acc_value;

  assign hw_wr = reg_wr && (reg_addr == sfm_pkg::PSW_ADDR);

  // Carry and half carry: hardware result beats a software write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyac_r <= sfm_pkg::PSW_RESET[7:6];
    end else if (op == sfm_pkg::OP_ADD || op == sfm_pkg::OP_ADD_WITH_CARRY ||
                 op == sfm_pkg::OP_SUBTRACT_WITH_BORROW) begin
      cyac_r[1] <= sub ? ~sum9[8] : sum9[8];
      cyac_r[0] <= sub ? ~nib5[4] : nib5[4];
    end else if (op == sfm_pkg::OP_MUL || op == sfm_pkg::OP_DIV ||
                 op == sfm_pkg::OP_OTHER) begin
      cyac_r <= 2'b00;
    end else if (hw_wr) begin
      if (bit_mode) begin
        if (bit_sel == 3'(sfm_pkg::BIT_CY))
          cyac_r[1] <= reg_wdata[0];
        if (bit_sel == 3'(sfm_pkg::BIT_AC))
          cyac_r[0] <= reg_wdata[0];
      end else begin
        cyac_r <= reg_wdata[7:6];
      end
    end
  end

  // User flags and bank select change only by software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      uf0_r  <= sfm_pkg::PSW_RESET[5];
      bank_r <= sfm_pkg::PSW_RESET[4:3];
      uf1_r  <= sfm_pkg::PSW_RESET[1];
    end else if (hw_wr) begin
      if (bit_mode) begin
        if (bit_sel == 3'(sfm_pkg::BIT_UF0))
          uf0_r <= reg_wdata[0];
        if (bit_sel == 3'(sfm_pkg::BIT_BS_HI))
          bank_r[1] <= reg_wdata[0];
        if (bit_sel == 3'(sfm_pkg::BIT_BS_LO))
          bank_r[0] <= reg_wdata[0];
        if (bit_sel == 3'(sfm_pkg::BIT_UF1))
          uf1_r <= reg_wdata[0];
      end else begin
        uf0_r  <= reg_wdata[5];
        bank_r <= reg_wdata[4:3];
        uf1_r  <= reg_wdata[1];
      end
    end
  end

  // Overflow: arithmetic result beats a software write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ov_r <= sfm_pkg::PSW_RESET[2];
    end else begin
      case (op)
        sfm_pkg::OP_ADD, sfm_pkg::OP_ADD_WITH_CARRY, sfm_pkg::OP_SUBTRACT_WITH_BORROW:
          ov_r <= ovf_add;
        sfm_pkg::OP_MUL:
          ov_r <= (prod[15:8] != 8'h00);
        sfm_pkg::OP_DIV:
          ov_r <= (alu_in.b == 8'h00);
        default: begin
          if (hw_wr && (!bit_mode || bit_sel == 3'(sfm_pkg::BIT_OV)))
            ov_r <= bit_mode ? reg_wdata[0] : reg_wdata[2];
        end
      endcase
    end
  end

  // Bit 0 has no storage; parity is substituted on every view
  assign program_status_word = {cyac_r, uf0_r, bank_r, ov_r, uf1_r, parity};

  // Read data one cycle after the strobe; bit mode returns bit in lsb
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= sfm_pkg::RD_ZERO;
    end else if (reg_rd && reg_addr == sfm_pkg::PSW_ADDR) begin
      rdata_r <= bit_mode ? {7'h00, program_status_word[bit_sel]}
                          : program_status_word;
    end else begin
      rdata_r <= sfm_pkg::RD_ZERO;
    end
  end
  assign reg_rdata = rdata_r;

  // Working register address: bank base plus register index
  assign bank_select   = bank_r;
  assign work_reg_addr = {3'b000, bank_select, work_reg_idx};

  // Code size by variant
  always_comb begin
    case (variant_sel)
      2'd0:    code_size = sfm_pkg::SIZE_V0;
      2'd1:    code_size = sfm_pkg::SIZE_V1;
      2'd2:    code_size = sfm_pkg::SIZE_V2;
      2'd3:    code_size = sfm_pkg::SIZE_V3;
      default: code_size = sfm_pkg::SIZE_V0;
    endcase
  end

  // Full 16-bit address space; only the implemented part responds
  assign code_in_range = code_addr < code_size;
  assign code_factory  = (variant_sel == 2'd0) &&
                         (code_addr >= sfm_pkg::FACTORY_BASE) &&
                         (code_addr <= sfm_pkg::FACTORY_TOP);
  // Code fetches come only from code_rd, never from data accesses
  assign code_mem_en   = code_rd && code_in_range;
  assign code_mem_addr = code_addr;
  // Firmware writes toward code are always dropped
  assign code_wr_blocked = code_wr;
endmodule : sfm_status_code

// ### tb/sfm_status_code_sva.sv
// Assertion checker for the status word and code map block
module sfm_status_code_sva (
  // Clock and reset
  input logic                 clk_sys,
  input logic                 rst,
  // Core and register side
  input sfm_pkg::sfm_alu_type alu_in,
  input logic [7:0]           acc_value,
  input logic [7:0]           reg_addr,
  input logic                 reg_wr,
  input logic                 reg_rd,
  input logic [7:0]           reg_rdata,
  input logic [2:0]           work_reg_idx,
  input logic [7:0]           work_reg_addr,
  input logic [7:0]           program_status_word,
  // Code space
  input logic [1:0]           variant_sel,
  input logic [15:0]          code_addr,
  input logic                 code_factory
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  sum9;
  logic [15:0] prod;
  assign sum9 = {1'b0, alu_in.a} + {1'b0, alu_in.b};
  assign prod = 16'(alu_in.a) * 16'(alu_in.b);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_par; program_status_word[0] == ^acc_value; endproperty
  a_par: assert property (p_par) else $error("parity bit wrong");
  property p_bank;
    work_reg_addr == {3'h0, program_status_word[4:3], work_reg_idx};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_cy;
    alu_in.op == sfm_pkg::OP_ADD |=> program_status_word[7] == $past(sum9[8]);
  endproperty
  a_cy: assert property (p_cy) else $error("carry after add wrong");
  property p_ov;
    alu_in.op == sfm_pkg::OP_ADD |=> program_status_word[2] ==
      $past(alu_in.a[7] == alu_in.b[7] && sum9[7] != alu_in.a[7]);
  endproperty
  a_ov: assert property (p_ov) else $error("add overflow wrong");
  property p_mul;
    alu_in.op == sfm_pkg::OP_MUL |=> program_status_word[2] == $past(prod > 255);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply overflow wrong");
  property p_div;
    alu_in.op == sfm_pkg::OP_DIV |=> program_status_word[2] == $past(alu_in.b == 0);
  endproperty
  a_div: assert property (p_div) else $error("divide overflow wrong");
  property p_user;
    !reg_wr |=> $stable(program_status_word[5]) && $stable(program_status_word[1]);
  endproperty
  a_user: assert property (p_user) else $error("user flag changed");
  property p_rd; reg_rd && reg_addr != 8'hD0 |=> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("foreign read not zero");
  property p_fact;
    code_factory == (variant_sel == 2'h0 && code_addr >= 16'h1E00 &&
      code_addr <= 16'h1FFF);
  endproperty
  a_fact: assert property (p_fact) else $error("factory region wrong");
endmodule : sfm_status_code_sva

bind sfm_status_code sfm_status_code_sva u_sfm_status_code_sva (.*);

// ### tb/tb_top.sv
// Self-checking bench for the status word and code map block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, reg_wr, reg_rd, bit_mode, code_rd, code_wr, code_mem_en;
  logic code_in_range, code_factory, code_wr_blocked;
  logic [7:0] acc_value, reg_addr, reg_wdata, reg_rdata, work_reg_addr;
  logic [7:0] program_status_word;
  logic [2:0] bit_sel, work_reg_idx;
  logic [1:0] bank_select, variant_sel;
  logic [15:0] code_addr, code_mem_addr, got;
  sfm_pkg::sfm_alu_type alu_in;
  int fails = 0, checked = 0, cyc = 0;
  sfm_status_code u_sfm_status_code (.*);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, d, input logic bm,
                     input logic [2:0] s);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata, bit_mode, bit_sel} <= {w, !w, a, d, bm, s};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'h0;
    #1 got = {8'h00, reg_rdata};
  endtask : bus
  task automatic alu(input logic [2:0] op, input logic [7:0] a, b);
    @(posedge clk_sys);
    alu_in <= '{sfm_pkg::sfm_op_type'(op), a, b};
    @(posedge clk_sys);
    alu_in.op <= sfm_pkg::OP_NONE;
    #1;
  endtask : alu
  task automatic cpt(input logic [1:0] v, input logic [15:0] a);
    @(posedge clk_sys);
    {variant_sel, code_addr, code_rd, code_wr} <= {v, a, 2'h3};
    #1 got = {code_in_range, code_mem_en, code_factory, code_wr_blocked};
  endtask : cpt
  task automatic t_regs;
    bus(0, 8'hD0, 8'h00, 0, 3'h0);
    chk(got, 16'h0000);
    bus(1, 8'hD0, 8'hFF, 0, 3'h0);
    bus(0, 8'hD0, 8'h00, 0, 3'h0);
    chk(got, 16'h00FE);
    bus(1, 8'hD1, 8'h00, 0, 3'h0);
    bus(0, 8'hD1, 8'h00, 0, 3'h0);
    chk(got + program_status_word, 16'h00FE);
    bus(1, 8'hD0, 8'h00, 1, 3'h5);
    bus(0, 8'hD0, 8'h00, 1, 3'h1);
    chk(got, 16'h0001);
    alu(3'h1, 8'h01, 8'h01);
    chk(program_status_word & 8'h3A, 16'h001A);
    for (int b = 0; b < 4; b++) begin
      bus(1, 8'hD0, 8'(b * 8), 0, 3'h0);
      chk({bank_select, work_reg_addr}, 16'(b * 264 + 7));
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_alu;
    // Entries: op, a, b, expected flags under the mask
    logic [31:0] tv[10] = '{32'h018888C4, 32'h06000004, 32'h01010100,
      32'h02404004, 32'h03100140, 32'h030001C0, 32'h04101004,
      32'h040F1100, 32'h05050004, 32'h05050100};
    foreach (tv[i]) begin
      alu(tv[i][26:24], tv[i][23:16], tv[i][15:8]);
      chk(program_status_word & (tv[i][26] ? 8'h04 : 8'hC4), tv[i][7:0]);
    end
    $display("test alu done");
  endtask : t_alu
  task automatic t_misc;
    logic [15:0] sz[4] = '{16'h2000, 16'h1000, 16'h0800, 16'h0600};
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_sys);
      acc_value <= 8'(i);
      #1 chk(program_status_word[0], ^8'(i));
    end
    for (int v = 0; v < 4; v++) begin
      cpt(2'(v), sz[v] - 16'h1);
      chk(got, v == 0 ? 16'hF : 16'hD);
      cpt(2'(v), sz[v]);
      chk(got, 16'h1);
    end
    cpt(2'h0, 16'h1DFF);
    chk(got, 16'hD);
    chk(code_mem_addr, 16'h1DFF);
    $display("test misc done");
  endtask : t_misc
  task automatic t_more;
    bus(1, 8'hD0, 8'h01, 1, 3'h2);
    bus(0, 8'hD0, 8'h00, 1, 3'h2);
    chk(got, 16'h0001);
    bus(1, 8'hD0, 8'h00, 1, 3'h4);
    chk(bank_select, 16'h0001);
    @(posedge clk_sys);
    code_rd <= 1'b0;
    #1 chk(code_mem_en, 16'h0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(program_status_word, {15'h0000, ^acc_value});
    $display("test more done");
  endtask : t_more
  task automatic close_out;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    {rst, reg_wr, reg_rd, bit_mode, code_rd, code_wr} = 6'h20;
    {acc_value, reg_addr, reg_wdata, bit_sel, variant_sel, code_addr} = '0;
    alu_in = '0;
    work_reg_idx = 3'h7;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_alu();
    t_misc();
    t_more();
    close_out();
  end
endmodule : tb_top
